// [logic/scr_device.sv]
// Command register end: decodes commands and tracks unlock sequences
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns

// Behaviour
// - Command register always reads zero
// - Host writes only defined command codes
// - 0x5D opens NVM unlock sequence
// - 0x5D then 0xA0 enables NVM write
// - 0x5D then 0xA5 enables NVM read
// - Other command except a repeated 0x5D aborts NVM unlock sequence
// - 0x73, 0xB4, 0x69 enables extended mode
// - Out-of-order command restarts extended sequence
// - Paging bit clear leaves extended mode
// - 0xB6 triggers reset to defaults
// - No acknowledge for reset command byte
module scr_device (
    input  wire logic i_clock,            // 125 MHz clock
    input  wire logic i_nrst,             // Synchronous reset, active low
    scr_if.device     bus,                // Register link from host
    input  wire logic i_paging_clear,     // Paging enable bit cleared
    output logic      o_nvm_write_en,     // NVM programming enabled
    output logic      o_nvm_read_en,      // NVM read enabled
    output logic      o_debug_pages,      // Debug and test pages visible
    output logic      o_soft_reset        // One-cycle reset to defaults
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Sequence trackers
    scr_pkg::scr_nvm_e nvm_r;          // NVM unlock tracker
    scr_pkg::scr_nvm_e nvm_nxt;
    scr_pkg::scr_ext_e ext_r;          // Extended-mode unlock tracker
    scr_pkg::scr_ext_e ext_nxt;
    // Sticky grants and levels
    logic              nvm_wen_r;      // NVM programming granted
    logic              nvm_wen_nxt;
    logic              nvm_ren_r;      // NVM read granted
    logic              nvm_ren_nxt;
    logic              ext_on_r;       // Debug and test pages visible
    logic              ext_on_nxt;
    // Link response
    logic              srst_r;         // Soft reset pulse
    logic              srst_nxt;
    logic              ack_r;          // Byte acknowledge
    logic              ack_nxt;
    // Decode of the current byte
    logic              cmd_wr;         // Write aimed at the command register
    logic              is_srst;        // Soft reset code on a command write
    logic [7:0]        c;              // Command byte on the link

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True when a strobed command write carries the given code; keeps
    // every comparison gated by the strobe so idle bus data never counts.
    // Used for the reset code and for the restart of the page sequence.
    function automatic logic cmd_hit(
        input logic       strobe,   // Command write this cycle
        input logic [7:0] value,    // Byte on the link
        input logic [7:0] code      // Code looked for
    );
        cmd_hit = strobe && (value == code);
    endfunction : cmd_hit

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // Only writes aimed at the command register move the trackers; the
    // address is compared in full because other registers share the link
    assign cmd_wr  = bus.wr && (bus.addr == scr_pkg::CMD_TRIGGER_ADDR);
    assign c       = bus.wdata;
    assign is_srst = cmd_hit(cmd_wr, c, scr_pkg::CMD_SOFT_RESET);

    // ------------------------------------------------------------------
    // NVM unlock tracker
    // ------------------------------------------------------------------
    // Next state; any command write that is neither the expected next step
    // nor a repeated opening step drops the tracker back to idle, so a stray byte costs a restart
    always_comb begin
        nvm_nxt     = nvm_r;
        nvm_wen_nxt = nvm_wen_r;
        nvm_ren_nxt = nvm_ren_r;
        if (cmd_wr) begin
            nvm_nxt = scr_pkg::SCR_NVM_IDLE;
            case (nvm_r)
                scr_pkg::SCR_NVM_IDLE: begin
                    if (c == scr_pkg::CMD_NVM_OPEN) begin
                        nvm_nxt = scr_pkg::SCR_NVM_ARMED;
                    end
                end
                scr_pkg::SCR_NVM_ARMED: begin
                    if (c == scr_pkg::CMD_NVM_WRITE) begin
                        nvm_wen_nxt = 1'b1;
                    end else if (c == scr_pkg::CMD_NVM_READ) begin
                        nvm_ren_nxt = 1'b1;
                    end else if (c == scr_pkg::CMD_NVM_OPEN) begin
                        // A repeated opening step keeps the sequence armed
                        nvm_nxt = scr_pkg::SCR_NVM_ARMED;
                    end
                end
                default: begin
                    nvm_nxt = scr_pkg::SCR_NVM_IDLE;
                end
            endcase
        end
        // Soft reset withdraws both grants
        if (is_srst) begin
            nvm_wen_nxt = 1'b0;
            nvm_ren_nxt = 1'b0;
        end
    end

    // Registers of the NVM tracker; grants are sticky levels
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            nvm_r     <= scr_pkg::SCR_NVM_IDLE;
            nvm_wen_r <= 1'b0;
            nvm_ren_r <= 1'b0;
        end else begin
            nvm_r     <= nvm_nxt;
            nvm_wen_r <= nvm_wen_nxt;
            nvm_ren_r <= nvm_ren_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Extended-mode unlock tracker
    // ------------------------------------------------------------------
    // Next state; the paging clear is a level, so the pages stay hidden
    // for as long as software holds the paging enable bit cleared, but a
    // completed sequence in the same cycle still wins
    always_comb begin
        ext_nxt    = ext_r;
        ext_on_nxt = ext_on_r && !i_paging_clear;
        if (cmd_wr) begin
            ext_nxt = scr_pkg::SCR_EXT_IDLE;
            case (ext_r)
                scr_pkg::SCR_EXT_STEP1: begin
                    if (c == scr_pkg::CMD_EXT_SECOND) begin
                        ext_nxt = scr_pkg::SCR_EXT_STEP2;
                    end
                end
                scr_pkg::SCR_EXT_STEP2: begin
                    if (c == scr_pkg::CMD_EXT_LAST) begin
                        ext_on_nxt = 1'b1;
                    end
                end
                default: begin
                    ext_nxt = scr_pkg::SCR_EXT_IDLE;
                end
            endcase
        end
        // A first step always (re)starts the sequence, even mid-way
        if (cmd_hit(cmd_wr, c, scr_pkg::CMD_EXT_FIRST)) begin
            ext_nxt = scr_pkg::SCR_EXT_STEP1;
        end
        // Soft reset hides the debug and test pages again
        if (is_srst) begin
            ext_on_nxt = 1'b0;
        end
    end

    // Registers of the extended-mode tracker
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            ext_r    <= scr_pkg::SCR_EXT_IDLE;
            ext_on_r <= 1'b0;
        end else begin
            ext_r    <= ext_nxt;
            ext_on_r <= ext_on_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Link response
    // ------------------------------------------------------------------
    // The reset pulse is registered so the rest of the chip sees a clean
    // one-cycle strobe; the reset byte gets no acknowledge because the
    // interface logic is itself being reset when the byte would be acked
    always_comb begin
        srst_nxt = is_srst;
        ack_nxt  = bus.wr && !is_srst;
    end

    // Registers of the link response
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            srst_r <= 1'b0;
            ack_r  <= 1'b0;
        end else begin
            srst_r <= srst_nxt;
            ack_r  <= ack_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The register is write-triggered and never holds a value, so a read
    // returns the fixed pattern whatever was written last
    assign bus.rdata      = scr_pkg::CMD_READ_VALUE;
    assign bus.ack        = ack_r;
    // Enables and the pulse come straight from flip-flops, no gating after
    assign o_nvm_write_en = nvm_wen_r;
    assign o_nvm_read_en  = nvm_ren_r;
    assign o_debug_pages  = ext_on_r;
    assign o_soft_reset   = srst_r;
endmodule : scr_device

// [logic/scr_pkg.sv]
// Shared constants and types for the sensor command register block
package scr_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_TRIGGER_ADDR  = 8'h7E;
    localparam logic [7:0] CMD_TRIGGER_RESET = 8'h00;
    localparam logic [7:0] CMD_READ_VALUE    = 8'h00;
    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_NONE          = 8'h00;
    localparam logic [7:0] CMD_NVM_OPEN      = 8'h5D;
    localparam logic [7:0] CMD_NVM_WRITE     = 8'hA0;
    localparam logic [7:0] CMD_NVM_READ      = 8'hA5;
    localparam logic [7:0] CMD_EXT_FIRST     = 8'h73;
    localparam logic [7:0] CMD_EXT_SECOND    = 8'hB4;
    localparam logic [7:0] CMD_EXT_LAST      = 8'h69;
    localparam logic [7:0] CMD_SOFT_RESET    = 8'hB6;
    // ------------------------------------------------------------------
    // Host-side register map of its own control port
    // ------------------------------------------------------------------
    localparam logic [1:0] HOST_CMD_ADDR     = 2'h0;
    localparam logic [1:0] HOST_STATUS_ADDR  = 2'h1;
    localparam logic [1:0] HOST_RDATA_ADDR   = 2'h2;
    // Sequence trackers
    typedef enum logic [1:0] {SCR_NVM_IDLE, SCR_NVM_ARMED} scr_nvm_e;
    typedef enum logic [1:0] {SCR_EXT_IDLE, SCR_EXT_STEP1, SCR_EXT_STEP2} scr_ext_e;
    // True for any command the device recognises
    function automatic logic is_defined_cmd(input logic [7:0] c);
        is_defined_cmd = (c == CMD_NVM_OPEN) || (c == CMD_NVM_WRITE) || (c == CMD_NVM_READ)
                      || (c == CMD_EXT_FIRST) || (c == CMD_EXT_SECOND)
                      || (c == CMD_EXT_LAST) || (c == CMD_SOFT_RESET);
    endfunction : is_defined_cmd
endpackage : scr_pkg

// [logic/scr_if.sv]
// Register-access link between host controller and command register end
`timescale 1ns/1ns
interface scr_if;
    logic       wr;      // Write strobe, one cycle
    logic       rd;      // Read strobe, one cycle
    logic [7:0] addr;    // Register address
    logic [7:0] wdata;   // Write data
    logic [7:0] rdata;   // Read data, fixed pattern, valid without rd
    logic       ack;     // Byte acknowledge, cycle after wr
    modport device (input wr, rd, addr, wdata, output rdata, ack);
    modport host   (output wr, rd, addr, wdata, input rdata, ack);
endinterface : scr_if

// [logic/scr_host.sv]
// Host end: issues commands on the register link from a software port
`timescale 1ns/1ns
module scr_host (
    input  wire logic       i_clock,     // 125 MHz clock
    input  wire logic       i_nrst,      // Synchronous reset, active low
    input  wire logic [1:0] i_addr,      // Software address
    input  wire logic [7:0] i_wdata,     // Software write data
    input  wire logic       i_wr,        // Software write strobe
    input  wire logic       i_rd,        // Software read strobe
    output logic      [7:0] o_rdata,     // Read data, cycle after i_rd
    scr_if.host             bus          // Register link to device
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic       wr_r, wr_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic       pend_r, pend_nxt;
    logic [7:0] sent_r, sent_nxt;
    logic       nack_r, nack_nxt;
    logic       err_r, err_nxt;
    logic [7:0] rd_r, rd_nxt;

    // Undefined codes are refused so only defined commands go out
    always_comb begin
        wr_nxt   = 1'b0;
        wd_nxt   = wd_r;
        // Remember the byte on the link so back-to-back writes keep its code
        pend_nxt = wr_r;
        sent_nxt = wr_r ? wd_r : sent_r;
        nack_nxt = nack_r;
        err_nxt  = err_r;
        rd_nxt   = 8'h00;
        if (i_wr && i_addr == scr_pkg::HOST_CMD_ADDR) begin
            if (scr_pkg::is_defined_cmd(i_wdata)) begin
                wr_nxt   = 1'b1;
                wd_nxt   = i_wdata;
                err_nxt  = 1'b0;
            end else begin
                err_nxt  = 1'b1;
            end
        end
        // Missing acknowledge after a reset command is expected, no retry
        if (pend_r) begin
            nack_nxt = !bus.ack && (sent_r != scr_pkg::CMD_SOFT_RESET);
        end
        if (i_rd) begin
            if (i_addr == scr_pkg::HOST_STATUS_ADDR) begin
                rd_nxt = {6'h00, err_r, nack_r};
            end else if (i_addr == scr_pkg::HOST_RDATA_ADDR) begin
                rd_nxt = bus.rdata;
            end else begin
                rd_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            wr_r   <= 1'b0;
            wd_r   <= 8'h00;
            pend_r <= 1'b0;
            sent_r <= 8'h00;
            nack_r <= 1'b0;
            err_r  <= 1'b0;
            rd_r   <= 8'h00;
        end else begin
            wr_r   <= wr_nxt;
            wd_r   <= wd_nxt;
            pend_r <= pend_nxt;
            sent_r <= sent_nxt;
            nack_r <= nack_nxt;
            err_r  <= err_nxt;
            rd_r   <= rd_nxt;
        end
    end

    assign bus.wr    = wr_r;
    assign bus.rd    = 1'b0;
    assign bus.addr  = scr_pkg::CMD_TRIGGER_ADDR;
    assign bus.wdata = wd_r;
    assign o_rdata   = rd_r;
endmodule : scr_host

// [bench/scr_link_monitor.sv]
// Concurrent checks on the host to device command link
`timescale 1ns/1ns
module scr_link_monitor (
    input wire logic       i_clock,         // Link clock
    input wire logic       i_nrst,          // Sync reset, active low
    input wire logic       i_wr,            // Write strobe
    input wire logic       i_rd,            // Read strobe
    input wire logic [7:0] i_addr,          // Register address
    input wire logic [7:0] i_wdata,         // Command byte
    input wire logic [7:0] i_rdata,         // Read data
    input wire logic       i_ack,           // Byte acknowledge
    input wire logic       i_paging_clear,  // Paging bit cleared
    input wire logic       i_nvm_write_en,  // NVM write enabled
    input wire logic       i_nvm_read_en,   // NVM read enabled
    input wire logic       i_debug_pages,   // Extended mode
    input wire logic       i_soft_reset     // Reset pulse
);
    // ------------------------------------------------------------------
    // Command history and assertions
    // ------------------------------------------------------------------
    logic [7:0] h1_r, h2_r, h3_r;  // Last three bytes, newest first
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // History lets causes be checked after a delayed enable
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            h1_r <= 8'h00;
            h2_r <= 8'h00;
            h3_r <= 8'h00;
        end else if (i_wr) begin
            h1_r <= i_wdata;
            h2_r <= h1_r;
            h3_r <= h2_r;
        end
    end
    a_read_zero: assert property (i_rdata == 8'h00) else $error("read data not zero");
    a_wr_defined: assert property (i_wr |-> i_addr == 8'h7E && !i_rd
        && i_wdata inside {8'h5D, 8'hA0, 8'hA5, 8'h73, 8'hB4, 8'h69, 8'hB6})
        else $error("bad command write");
    a_ack_data: assert property (i_wr && i_wdata != 8'hB6 |=> i_ack) else $error("no ack");
    a_nack_reset: assert property (i_wr && i_wdata == 8'hB6 |=> !i_ack)
        else $error("reset acked");
    a_ack_cause: assert property (i_ack |-> $past(i_wr)) else $error("stray ack");
    a_nvm_write: assert property (i_wr && i_wdata == 8'hA0 && h1_r == 8'h5D
        |=> i_nvm_write_en) else $error("nvm write not enabled");
    a_write_cause: assert property ($rose(i_nvm_write_en)
        |-> h1_r == 8'hA0 && h2_r == 8'h5D) else $error("nvm write enabled out of order");
    a_nvm_read: assert property (i_wr && i_wdata == 8'hA5 && h1_r == 8'h5D
        |=> i_nvm_read_en) else $error("nvm read not enabled");
    a_read_cause: assert property ($rose(i_nvm_read_en)
        |-> h1_r == 8'hA5 && h2_r == 8'h5D) else $error("nvm read enabled out of order");
    a_ext_enter: assert property (i_wr && i_wdata == 8'h69 && h1_r == 8'hB4 && h2_r == 8'h73
        |=> i_debug_pages) else $error("extended mode not entered");
    a_ext_cause: assert property ($rose(i_debug_pages) |-> h1_r == 8'h69
        && h2_r == 8'hB4 && h3_r == 8'h73) else $error("extended mode out of order");
    a_soft_reset: assert property (i_wr && i_wdata == 8'hB6 |=> i_soft_reset
        && !i_debug_pages && !i_nvm_write_en && !i_nvm_read_en) else $error("bad reset");
    a_reset_cause: assert property (i_soft_reset
        |-> $past(i_wr) && $past(i_wdata) == 8'hB6) else $error("stray reset pulse");
    a_page_leave: assert property (i_paging_clear && !i_wr |=> !i_debug_pages)
        else $error("extended mode kept");
    c_ext: cover property ($rose(i_debug_pages));
    c_write: cover property ($rose(i_nvm_write_en));
    c_read: cover property ($rose(i_nvm_read_en));
    c_reset: cover property (i_soft_reset);
endmodule : scr_link_monitor

// [bench/tb_sensor_command_register.sv]
// Testbench joining host and device ends of the command link
`timescale 1ns/1ns
module tb_sensor_command_register;
    // ------------------------------------------------------------------
    // Stimulus, table of sequences and hand-written cases
    // ------------------------------------------------------------------
    logic       i_clock = 1'b0;
    logic       i_nrst  = 1'b0;
    logic [1:0] i_addr  = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr    = 1'b0;
    logic       i_rd    = 1'b0;
    logic       i_paging_clear = 1'b0;
    logic [7:0] o_rdata;
    logic       o_nvm_write_en, o_nvm_read_en, o_debug_pages, o_soft_reset;
    int         failures = 0;
    int         num_checks = 0;
    logic [26:0] rows [6];  // Three commands, then expected {write, read, ext}
    scr_if bus ();
    always #4 i_clock = ~i_clock;
    scr_host u_scr_host (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .bus(bus));
    scr_device u_scr_device (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus),
        .i_paging_clear(i_paging_clear), .o_nvm_write_en(o_nvm_write_en),
        .o_nvm_read_en(o_nvm_read_en), .o_debug_pages(o_debug_pages),
        .o_soft_reset(o_soft_reset));
    scr_link_monitor u_scr_link_monitor (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr(bus.wr),
        .i_rd(bus.rd), .i_addr(bus.addr), .i_wdata(bus.wdata), .i_rdata(bus.rdata),
        .i_ack(bus.ack), .i_paging_clear(i_paging_clear), .i_nvm_write_en(o_nvm_write_en),
        .i_nvm_read_en(o_nvm_read_en), .i_debug_pages(o_debug_pages),
        .i_soft_reset(o_soft_reset));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // Strobe left high so consecutive calls run back to back
    task automatic sw_wr(input logic [7:0] d);
        i_addr <= 2'h0;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
    endtask : sw_wr
    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_paging_clear <= 1'b0;
        repeat (n) @(posedge i_clock);
        #1;
    endtask : idle
    task automatic sw_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clock);
    endtask : sw_rd
    function automatic logic [7:0] outs();
        return {5'h00, o_nvm_write_en, o_nvm_read_en, o_debug_pages};
    endfunction : outs
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        logic [7:0] d;
        rows = '{{24'h73B469, 3'b001}, {24'h735DA0, 3'b100}, {24'hB45DA5, 3'b010},
                 {24'h5D73A0, 3'b000}, {24'h73B4A5, 3'b000}, {24'h735D69, 3'b000}};
        repeat (10) @(posedge i_clock);
        i_nrst <= 1'b1;
        idle(1);
        check(outs(), 8'h00);
        sw_rd(2'h2, d);
        check(d, 8'h00);
        // Each row starts clean after a reset command
        foreach (rows[i]) begin
            sw_wr(8'hB6);
            sw_wr(rows[i][26:19]);
            sw_wr(rows[i][18:11]);
            sw_wr(rows[i][10:3]);
            idle(4);
            check(outs(), {5'h00, rows[i][2:0]});
        end
        // Refused codes leave extended mode standing
        sw_wr(8'hB6);
        sw_wr(8'h73);
        sw_wr(8'hB4);
        sw_wr(8'h69);
        sw_wr(8'h12);
        idle(4);
        check(outs(), 8'h01);
        sw_rd(2'h1, d);
        check(d & 8'h02, 8'h02);
        i_paging_clear <= 1'b1;
        @(posedge i_clock);
        idle(3);
        check(outs(), 8'h00);
        // Granted write enable, then soft reset withdraws it with one pulse
        sw_wr(8'h5D);
        sw_wr(8'hA0);
        idle(4);
        check(outs(), 8'h04);
        sw_wr(8'hB6);
        idle(1);
        check({7'h00, o_soft_reset}, 8'h01);
        check(outs(), 8'h00);
        idle(1);
        check({7'h00, o_soft_reset}, 8'h00);
        idle(2);
        sw_rd(2'h1, d);
        check(d & 8'h01, 8'h00);
        // Reset in mid-run clears a granted enable, then the link works again
        sw_wr(8'h5D);
        sw_wr(8'hA5);
        idle(4);
        check(outs(), 8'h02);
        i_nrst <= 1'b0;
        idle(2);
        i_nrst <= 1'b1;
        idle(1);
        check(outs(), 8'h00);
        sw_wr(8'h73);
        sw_wr(8'hB4);
        sw_wr(8'h69);
        idle(4);
        check(outs(), 8'h01);
        conclude();
    end
endmodule : tb_sensor_command_register
